// *** hdl/rtctod.sv ***
`timescale 1ns/1ps
`include "rtctod_defs.svh"
module rtctod #(
  parameter int unsigned TICK_DIV = 125000000
) (
  input  wire logic                   clk,
  input  wire logic                   arst_n,
  input  wire rtctod_pkg::rtctod_addr_t addr,
  input  wire rtctod_pkg::rtctod_byte_t wdata,
  input  wire logic                   wr_en,
  input  wire logic                   rd_en,
  input  wire logic [7:0]             cal_trim,
  output logic [7:0]                  rdata,
  output logic                        sec_tick
);
  import rtctod_pkg::*;

  rtctod_tick_if tk ();

  logic       stop_reg;
  logic       sign_reg;
  logic [3:0] sec_u_reg;
  logic [2:0] sec_t_reg;
  logic [3:0] min_u_reg;
  logic [2:0] min_t_reg;
  logic [3:0] hr_u_reg;
  logic [1:0] hr_t_reg;
  logic [2:0] wday_reg;
  logic       sec_wrap;
  logic       min_wrap;
  logic       hr_wrap;
  logic       tick;
  logic       wr_sec;
  logic       wr_min;
  logic       wr_hr;
  logic       wr_wday;
  logic [7:0] rdata_next;

  // ****************************************
  // time base
  // ****************************************
  assign tk.run  = !stop_reg;
  assign tk.sign = sign_reg;
  assign tk.trim = cal_trim;
  assign tick    = tk.tick;
  assign sec_tick = tick;

  rtctod_tick #(
    .TICK_DIV (TICK_DIV)
  ) u_tick (
    .clk    (clk),
    .arst_n (arst_n),
    .tk     (tk.gen)
  );

  // write decodes
  assign wr_sec  = wr_en && (addr == `RTCTOD_OFS_SEC);
  assign wr_min  = wr_en && (addr == `RTCTOD_OFS_MIN);
  assign wr_hr   = wr_en && (addr == `RTCTOD_OFS_HOUR);
  assign wr_wday = wr_en && (addr == `RTCTOD_OFS_WDAY);

  // carry terms, chained from seconds upward
  assign sec_wrap = tick && (sec_t_reg == `RTCTOD_TENS6_MAX)
                    && (sec_u_reg == `RTCTOD_UNITS_MAX);
  assign min_wrap = sec_wrap && (min_t_reg == `RTCTOD_TENS6_MAX)
                    && (min_u_reg == `RTCTOD_UNITS_MAX);
  assign hr_wrap  = min_wrap && (hr_t_reg == `RTCTOD_HTENS_MAX)
                    && (hr_u_reg == `RTCTOD_HUNITS_LAST);

  // ****************************************
  // calibration and control
  // ****************************************
  // reset leaves the clock running, add trim
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_reg <= 1'b0;
      sign_reg <= 1'b0;
    end else if (wr_en && (addr == `RTCTOD_OFS_CAL)) begin
      stop_reg <= wdata[`RTCTOD_CAL_STOP_BIT];
      sign_reg <= wdata[`RTCTOD_CAL_SIGN_BIT];
    end
  end

  // ****************************************
  // seconds
  // ****************************************
  // a software write wins over a tick in the same cycle
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sec_u_reg <= `RTCTOD_ZERO4;
      sec_t_reg <= `RTCTOD_ZERO3;
    end else if (wr_sec) begin
      sec_u_reg <= wdata[3:0];
      sec_t_reg <= wdata[6:4];
    end else if (tick) begin
      if (sec_u_reg == `RTCTOD_UNITS_MAX) begin
        sec_u_reg <= `RTCTOD_ZERO4;
        sec_t_reg <= (sec_t_reg == `RTCTOD_TENS6_MAX) ? `RTCTOD_ZERO3 : sec_t_reg + 3'd1;
      end else begin
        sec_u_reg <= sec_u_reg + 4'd1;
      end
    end
  end

  // ****************************************
  // minutes
  // ****************************************
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      min_u_reg <= `RTCTOD_ZERO4;
      min_t_reg <= `RTCTOD_ZERO3;
    end else if (wr_min) begin
      min_u_reg <= wdata[3:0];
      min_t_reg <= wdata[6:4];
    end else if (sec_wrap) begin
      if (min_u_reg == `RTCTOD_UNITS_MAX) begin
        min_u_reg <= `RTCTOD_ZERO4;
        min_t_reg <= (min_t_reg == `RTCTOD_TENS6_MAX) ? `RTCTOD_ZERO3 : min_t_reg + 3'd1;
      end else begin
        min_u_reg <= min_u_reg + 4'd1;
      end
    end
  end

  // ****************************************
  // hours, 24-hour BCD
  // ****************************************
  // 23 rolls to 00; 09 and 19 roll units into tens
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      hr_u_reg <= `RTCTOD_ZERO4;
      hr_t_reg <= `RTCTOD_ZERO2;
    end else if (wr_hr) begin
      hr_u_reg <= wdata[3:0];
      hr_t_reg <= wdata[5:4];
    end else if (min_wrap) begin
      if (hr_wrap) begin
        hr_u_reg <= `RTCTOD_ZERO4;
        hr_t_reg <= `RTCTOD_ZERO2;
      end else if (hr_u_reg == `RTCTOD_UNITS_MAX) begin
        hr_u_reg <= `RTCTOD_ZERO4;
        hr_t_reg <= hr_t_reg + 2'd1;
      end else begin
        hr_u_reg <= hr_u_reg + 4'd1;
      end
    end
  end

  // ****************************************
  // weekday ring
  // ****************************************
  // free-standing ring; no date logic looks at it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wday_reg <= `RTCTOD_WDAY_RST;
    end else if (wr_wday) begin
      wday_reg <= wdata[2:0];
    end else if (hr_wrap) begin
      if (wday_reg >= `RTCTOD_WDAY_MAX || wday_reg == `RTCTOD_ZERO3) begin
        wday_reg <= `RTCTOD_WDAY_MIN;
      end else begin
        wday_reg <= wday_reg + 3'd1;
      end
    end
  end

  // ****************************************
  // read path
  // ****************************************
  // unmapped addresses and unused bits read zero
  always_comb begin
    rdata_next = `RTCTOD_RST_BYTE;
    unique case (addr)
      `RTCTOD_OFS_CAL: begin
        rdata_next[`RTCTOD_CAL_STOP_BIT] = stop_reg;
        rdata_next[`RTCTOD_CAL_SIGN_BIT] = sign_reg;
      end
      `RTCTOD_OFS_WDAY: rdata_next = {5'h00, wday_reg};
      `RTCTOD_OFS_HOUR: rdata_next = {2'h0, hr_t_reg, hr_u_reg};
      `RTCTOD_OFS_MIN:  rdata_next = {1'h0, min_t_reg, min_u_reg};
      `RTCTOD_OFS_SEC:  rdata_next = {1'h0, sec_t_reg, sec_u_reg};
      default:          rdata_next = `RTCTOD_RST_BYTE;
    endcase
  end

  // data stands only in the cycle after the read strobe
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata <= `RTCTOD_RST_BYTE;
    end else if (rd_en) begin
      rdata <= rdata_next;
    end else begin
      rdata <= `RTCTOD_RST_BYTE;
    end
  end
endmodule

// *** hdl/rtctod_defs.svh ***
`ifndef RTCTOD_DEFS_SVH
`define RTCTOD_DEFS_SVH

// ****************************************
// register offsets
// ****************************************
`define RTCTOD_OFS_CAL   8'h08
`define RTCTOD_OFS_WDAY  8'h0C
`define RTCTOD_OFS_HOUR  8'h0B
`define RTCTOD_OFS_MIN   8'h0A
`define RTCTOD_OFS_SEC   8'h09

// ****************************************
// field positions and limits
// ****************************************
`define RTCTOD_CAL_STOP_BIT  7
`define RTCTOD_CAL_SIGN_BIT  5
`define RTCTOD_WDAY_MIN      3'h1
`define RTCTOD_WDAY_MAX      3'h7
`define RTCTOD_UNITS_MAX     4'h9
`define RTCTOD_TENS6_MAX     3'h5
`define RTCTOD_HTENS_MAX     2'h2
`define RTCTOD_HUNITS_LAST   4'h3
`define RTCTOD_ZERO4         4'h0
`define RTCTOD_ZERO3         3'h0
`define RTCTOD_ZERO2         2'h0
`define RTCTOD_RST_BYTE      8'h00
`define RTCTOD_WDAY_RST      3'h1
`endif

// *** hdl/rtctod_pkg.sv ***
package rtctod_pkg;
  typedef logic [7:0] rtctod_byte_t;
  typedef logic [7:0] rtctod_addr_t;
  // one-hot phase type; nothing in the register write path uses it
  typedef enum logic [1:0] {
    RTCTOD_IDLE = 2'b01,
    RTCTOD_HOLD = 2'b10
  } rtctod_phase_t;
endpackage

// *** hdl/rtctod_tick.sv ***
`timescale 1ns/1ps
`include "rtctod_defs.svh"
module rtctod_tick #(
  parameter int unsigned TICK_DIV = 125000000
) (
  input  wire logic         clk,
  input  wire logic         arst_n,
  rtctod_tick_if.gen        tk
);
  import rtctod_pkg::*;

  // trim can take up to 255 cycles off, so the period must stay well above that
  if (TICK_DIV < 512) begin : g_bad_div
    $error("TICK_DIV must leave room for trim");
  end

  logic [31:0] cnt_reg;
  logic [31:0] limit;

  // ****************************************
  // one-second enable with signed trim
  // ****************************************
  // trim lengthens or shortens the period; a plus sign speeds the clock up
  always_comb begin
    if (tk.sign) begin
      limit = TICK_DIV - 32'(tk.trim) - 32'd1;
    end else begin
      limit = TICK_DIV + 32'(tk.trim) - 32'd1;
    end
  end

  // counter freezes while stopped so a restart resumes the partial second
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_reg <= 32'h0;
    end else if (tk.run) begin
      if (cnt_reg >= limit) begin
        cnt_reg <= 32'h0;
      end else begin
        cnt_reg <= cnt_reg + 32'd1;
      end
    end
  end

  assign tk.tick = tk.run && (cnt_reg >= limit);
endmodule

// *** hdl/rtctod_tick_if.sv ***
`timescale 1ns/1ps
// tick path between the divider and the counters
interface rtctod_tick_if;
  logic run;
  logic sign;
  logic [7:0] trim;
  logic tick;
  modport gen (input run, input sign, input trim, output tick);
  modport use_side (output run, output sign, output trim, input tick);
endinterface

// *** verif/rtctod_bench.sv ***
`timescale 1ns/1ps
module rtctod_bench;
  import rtctod_pkg::*;
  localparam int unsigned TDIV = 600; // short second for sim
  localparam logic [7:0]  TRIM = 8'h40;
  logic         clk = 1'b0;
  logic         arst_n = 1'b0;
  logic         wr_en = 1'b0;
  logic         rd_en = 1'b0;
  logic         sec_tick;
  rtctod_addr_t addr = 8'h00;
  rtctod_byte_t wdata = 8'h00;
  logic [7:0]   rdata;
  int           n_fail = 0;
  int           checked = 0;
  logic [7:0]   ofs [5] = '{8'h08, 8'h09, 8'h0A, 8'h0B, 8'h0C};
  logic [7:0]   rsv [5] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h01};
  logic [7:0]   ffv [5] = '{8'h00, 8'h7F, 8'h7F, 8'h3F, 8'h07};
  logic [31:0]  t_in [4] = '{32'h07235959, 32'h03095959, 32'h05190959, 32'h02000009};
  logic [31:0]  t_out [4] = '{32'h01000000, 32'h03100000, 32'h05191000, 32'h02000010};
  rtctod #(.TICK_DIV(TDIV)) DUT (.clk(clk), .arst_n(arst_n), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .cal_trim(TRIM), .rdata(rdata), .sec_tick(sec_tick));
  // free-running clock
  always #4 clk = ~clk;
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // spare edge at the end so strobes never toggle twice in one step
  task wr(input logic [7:0] a, input logic [7:0] d);
    addr <= a; wdata <= d; wr_en <= 1'b1;
    @(posedge clk); wr_en <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input logic [7:0] a, output logic [7:0] v);
    addr <= a; rd_en <= 1'b1;
    @(posedge clk); rd_en <= 1'b0;
    #1 v = rdata;
    @(posedge clk);
  endtask
  task chk_rd(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    check($sformatf("reg %h", a), v, e);
  endtask
  // sample the tick mid-cycle, where it is settled, then finish on the edge that takes it
  task wait_tick(output int n);
    n = 0;
    do begin @(negedge clk); n++; end while (sec_tick !== 1'b1 && n < 2000);
    if (sec_tick !== 1'b1) begin
      n_fail++;
      $display("wrong value tick wait expected 1 seen %b", sec_tick);
      wrap_up;
    end
    @(posedge clk);
  endtask
  initial begin
    logic [7:0] w, h, m, s;
    int n;
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    foreach (ofs[i]) chk_rd(ofs[i], rsv[i]);
    $display("test reset done");
    wait_tick(n);
    for (int i = 1; i < 5; i++) begin wr(ofs[i], 8'hFF); chk_rd(ofs[i], ffv[i]); end
    wr(8'h0D, 8'h5A); chk_rd(8'h0D, 8'h00);
    $display("test unused bits done");
    foreach (t_in[i]) begin
      wait_tick(n);
      for (int k = 0; k < 4; k++) wr(ofs[4 - k], t_in[i][31 - 8 * k -: 8]);
      wait_tick(n);
      rd(8'h0C, w); rd(8'h0B, h); rd(8'h0A, m); rd(8'h09, s);
      check("time", {w, h, m, s}, t_out[i]);
    end
    $display("test carries done");
    wr(8'h08, 8'h20); chk_rd(8'h08, 8'h20);
    wait_tick(n); wait_tick(n); check("short period", n, TDIV - TRIM);
    wr(8'h08, 8'h00);
    wait_tick(n); wait_tick(n); check("long period", n, TDIV + TRIM);
    $display("test trim done");
    wr(8'h08, 8'h80); rd(8'h09, s); n = 0;
    repeat (TDIV + 100) begin @(negedge clk); if (sec_tick !== 1'b0) n++; end
    @(posedge clk);
    check("ticks stopped", n, 0); chk_rd(8'h09, s); chk_rd(8'h08, 8'h80);
    wr(8'h08, 8'h00); wait_tick(n); check("restart", n <= TDIV + TRIM, 1'b1);
    $display("test stop done");
    wrap_up;
  end
endmodule
bind rtctod rtctod_checker #(.TICK_DIV(TICK_DIV)) u_chk (.clk(clk), .arst_n(arst_n),
  .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .cal_trim(cal_trim),
  .rdata(rdata), .sec_tick(sec_tick));

// *** verif/rtctod_checker.sv ***
`timescale 1ns/1ps
module rtctod_checker #(
  parameter int unsigned TICK_DIV = 125000000
) (
  input wire logic                     clk,
  input wire logic                     arst_n,
  input wire rtctod_pkg::rtctod_addr_t addr,
  input wire rtctod_pkg::rtctod_byte_t wdata,
  input wire logic                     wr_en,
  input wire logic                     rd_en,
  input wire logic [7:0]               cal_trim,
  input wire logic [7:0]               rdata,
  input wire logic                     sec_tick
);
  import rtctod_pkg::*;
  logic        stop_reg;
  logic        sign_reg;
  logic        clean_reg;
  logic [31:0] gap_reg;
  logic [31:0] per_w;
  wire         cal_wr = wr_en && addr == 8'h08;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  // shadow of the control bits
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      stop_reg <= 1'b0;
      sign_reg <= 1'b0;
    end else if (cal_wr) begin
      stop_reg <= wdata[7];
      sign_reg <= wdata[5];
    end
  end
  // gap since last tick; any control write spoils the interval
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      gap_reg   <= 32'h0;
      clean_reg <= 1'b0;
    end else if (cal_wr) begin
      clean_reg <= 1'b0;
    end else if (sec_tick) begin
      gap_reg   <= 32'h0;
      clean_reg <= 1'b1;
    end else begin
      gap_reg <= gap_reg + 32'h1;
    end
  end
  assign per_w = sign_reg ? TICK_DIV - cal_trim : TICK_DIV + cal_trim;
  // ****
  // properties
  // ****
  property p_rd_idle; !$past(rd_en) |-> rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("rdata not zero");
  property p_unmap;
    $past(rd_en) && !($past(addr) inside {[8'h08:8'h0C]}) |-> rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read");
  property p_wday; $past(rd_en) && $past(addr) == 8'h0C |-> rdata[7:3] == 5'h00; endproperty
  a_wday: assert property (p_wday) else $error("weekday upper bits");
  property p_hour; $past(rd_en) && $past(addr) == 8'h0B |-> rdata[7:6] == 2'h0; endproperty
  a_hour: assert property (p_hour) else $error("hour upper bits");
  property p_ms; $past(rd_en) && $past(addr) inside {8'h09, 8'h0A} |-> !rdata[7]; endproperty
  a_ms: assert property (p_ms) else $error("min or sec bit 7");
  property p_stop; stop_reg |-> !sec_tick; endproperty
  a_stop: assert property (p_stop) else $error("tick while stopped");
  property p_period; sec_tick && clean_reg |-> gap_reg == per_w - 32'h1; endproperty
  a_period: assert property (p_period) else $error("tick period");
  property p_pulse; sec_tick |=> !sec_tick; endproperty
  a_pulse: assert property (p_pulse) else $error("tick too long");
  c_plus: cover property (sec_tick && clean_reg && sign_reg);
  c_stop: cover property (stop_reg ##1 !stop_reg);
  c_wday: cover property ($past(rd_en) && $past(addr) == 8'h0C);
endmodule
